// file: src/spbd_pkg.sv
// Purpose: constants and types for the speaker, bypass and dither register slice
// Assumes: eight-bit registers on a plain address/strobe port
// Notes:   offsets are the printed register numbers
package spbd_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  localparam logic [6:0] RSVD_70_OFF    = 7'h46;
  localparam logic [6:0] RSVD_71_OFF    = 7'h47;
  localparam logic [6:0] RSVD_72_OFF    = 7'h48;
  localparam logic [6:0] SPK_CTRL_OFF   = 7'h49;
  localparam logic [6:0] RSVD_74_OFF    = 7'h4a;
  localparam logic [6:0] RSVD_75_OFF    = 7'h4b;
  localparam logic [6:0] DITHER_OFF     = 7'h4c;
  localparam logic [6:0] RSVD_77_OFF    = 7'h4d;
  localparam logic [6:0] RSVD_78_OFF    = 7'h4e;
  localparam logic [6:0] RSVD_79_OFF    = 7'h4f;

  localparam int unsigned LGAIN_LSB     = 6;
  localparam int unsigned RGAIN_LSB     = 4;
  localparam int unsigned LEN_BIT       = 3;
  localparam int unsigned REN_BIT       = 2;
  localparam int unsigned BYP_BIT       = 1;
  localparam int unsigned BOOT_BIT      = 0;
  localparam int unsigned LDITH_LSB     = 4;
  localparam int unsigned RDITH_LSB     = 0;

  localparam logic [7:0] SPK_CTRL_RST   = 8'h00;
  localparam logic [7:0] DITHER_RST     = 8'h00;
  localparam logic [7:0] RSVD_VALUE     = 8'h00;
  localparam logic [7:0] SPK_WO_MASK    = 8'h0e;

  localparam logic [4:0] GAIN_STEP_DB   = 5'h06;
  localparam logic [6:0] DITH_STEP_MV   = 7'h0f;

  typedef struct packed {
    logic [1:0] left_gain;
    logic [1:0] right_gain;
    logic       left_en;
    logic       right_en;
    logic       bypass_en;
    logic       boot_clk_en;
  } spbd_spk_t;

  typedef struct packed {
    logic [3:0] left;
    logic [3:0] right;
  } spbd_dith_t;

  typedef struct packed {
    logic       enable;
    logic       negative;
    logic [6:0] mv;
  } spbd_dlevel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } spbd_req_t;

endpackage : spbd_pkg

// file: src/spbd_regs.sv
// Purpose: speaker amplifier, bypass switch and ADC dither control registers
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   write-only bits read back as zero; reserved locations read zero
//
// Summary of operation
// - left speaker gain in bits 7:6 of 0x49 decodes to 0/6/12/18 dB and is read/write.
// - right speaker gain in bits 5:4 of 0x49 decodes the same way and is read/write.
// - bit 3 of 0x49 is write-only and enables the left speaker channel, reset off.
// - bit 2 of 0x49 is write-only and enables the right speaker channel, reset off.
// - bit 1 of 0x49 is write-only and enables the bypass switch, reset off.
// - bit 0 of 0x49 is read/write and enables the bypass bootstrap clock, reset off.
// - left dither in bits 7:4 of 0x4c is sign-magnitude, 15 mV steps, 0000/1000 off.
// - right dither in bits 3:0 of 0x4c uses the same code, read/write, reset 0000.
// - reserved locations read all zeros and software must never write them.
`timescale 1ns/100ps

module spbd_regs
  import spbd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rdata,
  output logic      [4:0]        left_gain_db,
  output logic      [4:0]        right_gain_db,
  output logic                   left_spk_en,
  output logic                   right_spk_en,
  output logic                   bypass_en,
  output logic                   boot_clk_en,
  output spbd_dlevel_t           left_dither,
  output spbd_dlevel_t           right_dither,
  output logic                   rsvd_wr_err
);

  spbd_spk_t          spk_q;
  spbd_spk_t          spk_d;
  spbd_dith_t         dith_q;
  spbd_dith_t         dith_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic               rsvd_q;
  logic               rsvd_d;
  spbd_req_t          req;

  function automatic logic [4:0] gain_db(input logic [1:0] code);
    gain_db = 5'(code * GAIN_STEP_DB);
  endfunction : gain_db

  function automatic spbd_dlevel_t dith_decode(input logic [3:0] code);
    spbd_dlevel_t v;
    v.enable   = (code[2:0] != 3'h0);
    v.negative = code[3] & v.enable;
    v.mv       = 7'(code[2:0] * DITH_STEP_MV);
    dith_decode = v;
  endfunction : dith_decode

  function automatic logic is_reserved(input logic [ADDR_W-1:0] a);
    is_reserved = (a == RSVD_70_OFF) || (a == RSVD_71_OFF) || (a == RSVD_72_OFF)
               || (a == RSVD_74_OFF) || (a == RSVD_75_OFF) || (a == RSVD_77_OFF)
               || (a == RSVD_78_OFF) || (a == RSVD_79_OFF);
  endfunction : is_reserved

  always_comb begin
    req.addr  = addr;
    req.wdata = wdata;
    req.wr    = wr_stb;
    req.rd    = rd_stb;
  end

  // speaker control register
  always_comb begin
    spk_d = spk_q;
    if (req.wr && req.addr == SPK_CTRL_OFF) begin
      spk_d.left_gain   = req.wdata[LGAIN_LSB +: 2];
      spk_d.right_gain  = req.wdata[RGAIN_LSB +: 2];
      spk_d.left_en     = req.wdata[LEN_BIT];
      spk_d.right_en    = req.wdata[REN_BIT];
      spk_d.bypass_en   = req.wdata[BYP_BIT];
      spk_d.boot_clk_en = req.wdata[BOOT_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spk_q <= spbd_spk_t'(SPK_CTRL_RST);
    end else begin
      spk_q <= spk_d;
    end
  end

  // dither level register
  always_comb begin
    dith_d = dith_q;
    if (req.wr && req.addr == DITHER_OFF) begin
      dith_d.left  = req.wdata[LDITH_LSB +: 4];
      dith_d.right = req.wdata[RDITH_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dith_q <= spbd_dith_t'(DITHER_RST);
    end else begin
      dith_q <= dith_d;
    end
  end

  // reserved write flag, one cycle pulse, nothing stored
  always_comb begin
    rsvd_d = req.wr && is_reserved(req.addr);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsvd_q <= 1'b0;
    end else begin
      rsvd_q <= rsvd_d;
    end
  end

  // read mux, data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = RSVD_VALUE;
    if (req.rd) begin
      case (req.addr)
        SPK_CTRL_OFF: begin
          rdata_d = {spk_q.left_gain, spk_q.right_gain, 3'h0, spk_q.boot_clk_en};
        end
        DITHER_OFF: begin
          rdata_d = {dith_q.left, dith_q.right};
        end
        default: begin
          rdata_d = RSVD_VALUE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= RSVD_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata         = rdata_q;
  assign left_gain_db  = gain_db(spk_q.left_gain);
  assign right_gain_db = gain_db(spk_q.right_gain);
  assign left_spk_en   = spk_q.left_en;
  assign right_spk_en  = spk_q.right_en;
  assign bypass_en     = spk_q.bypass_en;
  assign boot_clk_en   = spk_q.boot_clk_en;
  assign left_dither   = dith_decode(dith_q.left);
  assign right_dither  = dith_decode(dith_q.right);
  assign rsvd_wr_err   = rsvd_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // speaker control writes
  left_gain_a: assert property (
    wr_stb && addr == SPK_CTRL_OFF |=> left_gain_db == 5'($past(wdata[7:6]) * 6))
    else $error("left gain decode wrong");

  right_gain_a: assert property (
    wr_stb && addr == SPK_CTRL_OFF |=> right_gain_db == 5'($past(wdata[5:4]) * 6))
    else $error("right gain decode wrong");

  left_en_a: assert property (
    wr_stb && addr == SPK_CTRL_OFF |=> left_spk_en == $past(wdata[3]))
    else $error("left enable not taken");

  right_en_a: assert property (
    wr_stb && addr == SPK_CTRL_OFF |=> right_spk_en == $past(wdata[2]))
    else $error("right enable not taken");

  bypass_wr_a: assert property (
    wr_stb && addr == SPK_CTRL_OFF |=> bypass_en == $past(wdata[1]))
    else $error("bypass enable not taken");

  boot_wr_a: assert property (
    wr_stb && addr == SPK_CTRL_OFF |=> boot_clk_en == $past(wdata[0]))
    else $error("bootstrap enable not taken");

  gain_range_a: assert property (
    left_gain_db <= 5'h12 && right_gain_db <= 5'h12)
    else $error("gain out of range");

  // speaker control holds between writes
  bypass_hold_a: assert property (
    !(wr_stb && addr == SPK_CTRL_OFF) |=> $stable(bypass_en))
    else $error("bypass changed without write");

  left_gain_hold_a: assert property (
    !(wr_stb && addr == SPK_CTRL_OFF) |=> $stable(left_gain_db))
    else $error("left gain changed without write");

  right_gain_hold_a: assert property (
    !(wr_stb && addr == SPK_CTRL_OFF) |=> $stable(right_gain_db))
    else $error("right gain changed without write");

  left_en_hold_a: assert property (
    !(wr_stb && addr == SPK_CTRL_OFF) |=> $stable(left_spk_en))
    else $error("left enable changed without write");

  right_en_hold_a: assert property (
    !(wr_stb && addr == SPK_CTRL_OFF) |=> $stable(right_spk_en))
    else $error("right enable changed without write");

  boot_hold_a: assert property (
    !(wr_stb && addr == SPK_CTRL_OFF) |=> $stable(boot_clk_en))
    else $error("bootstrap changed without write");

  // speaker control readback
  boot_read_a: assert property (
    rd_stb && addr == SPK_CTRL_OFF |=> rdata[0] == boot_clk_en)
    else $error("bootstrap readback wrong");

  left_read_a: assert property (
    rd_stb && addr == SPK_CTRL_OFF |=> 5'(rdata[7:6] * 6) == left_gain_db)
    else $error("left gain readback wrong");

  right_read_a: assert property (
    rd_stb && addr == SPK_CTRL_OFF |=> 5'(rdata[5:4] * 6) == right_gain_db)
    else $error("right gain readback wrong");

  wo_zero_a: assert property (
    rd_stb && addr == SPK_CTRL_OFF |=> rdata[3:1] == 3'h0)
    else $error("write-only bits read back");

  // dither decode
  left_dith_a: assert property (
    wr_stb && addr == DITHER_OFF && wdata[6:4] == 3'h0 |=> !left_dither.enable)
    else $error("left dither not disabled");

  left_dith_on_a: assert property (
    wr_stb && addr == DITHER_OFF && wdata[6:4] != 3'h0 |=> left_dither.enable)
    else $error("left dither not enabled");

  left_dith_mag_a: assert property (
    wr_stb && addr == DITHER_OFF |=> left_dither.mv == 7'($past(wdata[6:4]) * 15))
    else $error("left dither level wrong");

  left_dith_neg_a: assert property (
    wr_stb && addr == DITHER_OFF
      |=> left_dither.negative == ($past(wdata[7]) && $past(wdata[6:4]) != 3'h0))
    else $error("left dither polarity wrong");

  right_dith_a: assert property (
    wr_stb && addr == DITHER_OFF |=> right_dither.mv == 7'($past(wdata[2:0]) * 15)
      && right_dither.negative == ($past(wdata[3]) && $past(wdata[2:0]) != 3'h0))
    else $error("right dither decode wrong");

  right_dith_off_a: assert property (
    wr_stb && addr == DITHER_OFF && wdata[2:0] == 3'h0 |=> !right_dither.enable)
    else $error("right dither not disabled");

  dith_range_a: assert property (
    left_dither.mv <= 7'h69 && right_dither.mv <= 7'h69)
    else $error("dither level out of range");

  left_dith_hold_a: assert property (
    !(wr_stb && addr == DITHER_OFF) |=> $stable(left_dither))
    else $error("left dither changed without write");

  right_dith_hold_a: assert property (
    !(wr_stb && addr == DITHER_OFF) |=> $stable(right_dither))
    else $error("right dither changed without write");

  dith_read_a: assert property (
    rd_stb && addr == DITHER_OFF |=> left_dither.mv == 7'(rdata[6:4] * 15)
      && right_dither.mv == 7'(rdata[2:0] * 15))
    else $error("dither readback wrong");

  // reserved locations
  rsvd_read_a: assert property (
    rd_stb && is_reserved(addr) |=> rdata == 8'h00)
    else $error("reserved read not zero");

  rsvd_err_a: assert property (
    wr_stb && is_reserved(addr) |=> rsvd_wr_err)
    else $error("reserved write not flagged");

  rsvd_pulse_a: assert property (
    !(wr_stb && is_reserved(addr)) |=> !rsvd_wr_err)
    else $error("reserved flag without reserved write");

  rsvd_keep_spk_a: assert property (
    wr_stb && is_reserved(addr) |=> $stable({left_gain_db, right_gain_db,
      left_spk_en, right_spk_en, bypass_en, boot_clk_en}))
    else $error("reserved write changed speaker control");

  rsvd_keep_dith_a: assert property (
    wr_stb && is_reserved(addr) |=> $stable({left_dither, right_dither}))
    else $error("reserved write changed dither");

  // read data timing
  rd_only_a: assert property (
    !rd_stb |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  spk_wr_c: cover property (wr_stb && addr == SPK_CTRL_OFF && wdata == 8'hff);
  bypass_boot_c: cover property (bypass_en && boot_clk_en);
  dith_neg_c: cover property (left_dither.negative && right_dither.negative);
  rsvd_wr_c: cover property (rsvd_wr_err);
  wr_rd_c: cover property (wr_stb && addr == DITHER_OFF ##1 rd_stb && addr == DITHER_OFF);

endmodule : spbd_regs

// file: tb/spbd_regs_tb_top.sv
// Purpose: self-checking bench for the speaker, bypass and dither register slice
// Assumes: one 200 MHz clock, bench drives the register port itself
// Notes:   expected values come from a bench model of both registers
`timescale 1ns/100ps

module spbd_regs_tb_top import spbd_pkg::*;;
  logic              clk;
  logic              reset_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_stb;
  logic              rd_stb;
  logic [DATA_W-1:0] rdata;
  logic [4:0]        left_gain_db;
  logic [4:0]        right_gain_db;
  logic              left_spk_en;
  logic              right_spk_en;
  logic              bypass_en;
  logic              boot_clk_en;
  spbd_dlevel_t      left_dither;
  spbd_dlevel_t      right_dither;
  logic              rsvd_wr_err;
  logic [7:0]        sm;
  logic [7:0]        dm;
  int                fails;
  int                total_checks;
  int                i;

  spbd_regs uut (
    .clk           (clk),
    .reset_n       (reset_n),
    .addr          (addr),
    .wdata         (wdata),
    .wr_stb        (wr_stb),
    .rd_stb        (rd_stb),
    .rdata         (rdata),
    .left_gain_db  (left_gain_db),
    .right_gain_db (right_gain_db),
    .left_spk_en   (left_spk_en),
    .right_spk_en  (right_spk_en),
    .bypass_en     (bypass_en),
    .boot_clk_en   (boot_clk_en),
    .left_dither   (left_dither),
    .right_dither  (right_dither),
    .rsvd_wr_err   (rsvd_wr_err)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk

  // sign-magnitude dither decode, 15 mV steps
  function logic [8:0] dexp(input logic [3:0] c);
    return {c[2:0] != 3'h0, c[3] && c[2:0] != 3'h0, 7'(c[2:0] * 7'h0f)};
  endfunction : dexp

  task ck_out();
    chk("left_gain", 9'(sm[7:6] * 6), 9'(left_gain_db));
    chk("right_gain", 9'(sm[5:4] * 6), 9'(right_gain_db));
    chk("enables", 9'(sm[3:0]), 9'({left_spk_en, right_spk_en, bypass_en, boot_clk_en}));
    chk("left_dither", dexp(dm[7:4]), left_dither);
    chk("right_dither", dexp(dm[3:0]), right_dither);
  endtask : ck_out

  task wr(input logic [6:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    if (a == 7'h49) sm = d;
    if (a == 7'h4c) dm = d;
    #1;
    chk("rsvd_err", 9'(a >= 7'h46 && a <= 7'h4f && a != 7'h49 && a != 7'h4c), 9'(rsvd_wr_err));
    ck_out();
  endtask : wr

  task rd(input logic [6:0] a, input logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", 9'(e), 9'(rdata));
  endtask : rd

  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    {reset_n, wr_stb, rd_stb, addr, wdata, sm, dm} = '0;
    fails = 0;
    total_checks = 0;
    void'($urandom(56));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    ck_out();
    rd(7'h49, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr(7'h49, {i[3:0], 4'($urandom)});
      rd(7'h49, sm & 8'hf1);
      wr(7'h4c, {i[3:0], 4'(15 - i)});
      rd(7'h4c, dm);
    end
    // reserved writes must not disturb the live registers
    for (i = 'h46; i <= 'h4f; i++) begin
      wr(7'(i), 8'($urandom));
      rd(7'(i), i == 'h49 ? sm & 8'hf1 : (i == 'h4c ? dm : 8'h00));
    end
    rd(7'h50, 8'h00);
    wr(7'h00, 8'hff);
    reset_n <= 1'b0;
    sm = 8'h00;
    dm = 8'h00;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    ck_out();
    rd(7'h4c, 8'h00);
    report_and_stop();
  end
endmodule : spbd_regs_tb_top
